// ==== bench/actuator_parameter_supervisor_assertions.sv ====
`include "actuator_defines.svh"
`default_nettype none
module actuator_parameter_supervisor_assertions (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Drive and teach inputs
  input wire logic moving_i,
  input wire logic servo_on_i,
  input wire logic push_active_i,
  input wire logic teach_mode_i,
  input wire logic jog_i,
  // Outputs watched
  input wire logic zone_b_output_o,
  input wire logic moving_output_o,
  input wire logic push_done_o,
  input wire logic home_dir_o,
  input wire actuator_pkg::pos_t home_offset_o,
  input wire logic [7:0] hold_cur_limit_o,
  input wire logic [15:0] jog_speed_o,
  input wire logic phase_detect_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import actuator_pkg::*;
  logic restart_w;
  logic [3:0] since_r;
  logic seen_r;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////
  // Restart strobe; reset also reloads settings
  assign restart_w = psel && penable && pready && pwrite && paddr == `REG_CTRL && pwdata[`CTRL_RESTART_BIT];
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || restart_w) begin
      since_r <= 4'h0;
    end else if (since_r != 4'hF) begin
      since_r <= since_r + 4'h1;
    end
  end
  // Phase detection seen since reset
  always_ff @(posedge clock_i) begin
    seen_r <= rst_n_i && (seen_r || phase_detect_o);
  end
  sequence push_idle_s;
    !push_active_i [*3];
  endsequence
  ////////////////////
  settle_after_restart_a: assert property (($changed(home_dir_o) || $changed(home_offset_o)
    || $changed(hold_cur_limit_o)) |-> since_r <= 4'h5) else $error("setting moved without restart");
  zone_b_pattern_a: assert property (zone_b_output_o |-> !moving_output_o)
    else $error("zone b beside moving output");
  moving_follow_a: assert property (moving_output_o |-> $past(moving_i))
    else $error("moving output without motion");
  jog_gate_a: assert property (!$past(teach_mode_i && jog_i) |-> jog_speed_o == 16'h0)
    else $error("jog speed outside teach jog");
  push_idle_clear_a: assert property (push_idle_s |=> !push_done_o)
    else $error("push done while not pushing");
  push_done_cause_a: assert property ($rose(push_done_o) |-> $past(push_active_i))
    else $error("push done rose without push");
  phase_cause_a: assert property (phase_detect_o |-> $past(servo_on_i) ##1 !phase_detect_o)
    else $error("phase pulse without servo on");
  phase_once_a: assert property (phase_detect_o |-> !seen_r)
    else $error("second phase detection");
  bus_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access");
endmodule : actuator_parameter_supervisor_assertions
bind actuator_parameter_supervisor actuator_parameter_supervisor_assertions chk_u (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .moving_i(moving_i), .servo_on_i(servo_on_i),
  .push_active_i(push_active_i), .teach_mode_i(teach_mode_i), .jog_i(jog_i),
  .zone_b_output_o(zone_b_output_o), .moving_output_o(moving_output_o), .push_done_o(push_done_o),
  .home_dir_o(home_dir_o), .home_offset_o(home_offset_o), .hold_cur_limit_o(hold_cur_limit_o),
  .jog_speed_o(jog_speed_o), .phase_detect_o(phase_detect_o)
);
`default_nettype wire

// ==== bench/actuator_parameter_supervisor_bench.sv ====
`include "actuator_defines.svh"
`default_nettype none
module actuator_parameter_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, zone_a_output_o, zone_b_output_o, moving_output_o;
  logic soft_limit_pos_o, soft_limit_neg_o, push_done_o, home_dir_o, phase_detect_o, phase_dir_o, hit;
  logic [7:0] paddr, hold_cur_limit_o, home_cur_limit_o;
  logic [31:0] prdata, pwdata, q;
  logic [15:0] jog_speed_o;
  logic [4:0] flags;
  actuator_pkg::pos_t pos_i = 32'h0;
  actuator_pkg::pos_t home_offset_o;
  logic moving_i = 1'b0, servo_on_i = 1'b0, push_active_i = 1'b0, at_push_level_i = 1'b0;
  logic teach_mode_i = 1'b0, jog_i = 1'b0, capture_i = 1'b0;
  logic [3:0] capture_idx_i = 4'h0;
  int error_cnt = 0;
  int checked = 0;
  assign flags = {moving_output_o, soft_limit_pos_o, soft_limit_neg_o, zone_a_output_o, zone_b_output_o};
  ////////////////////
  // Short tick keeps push tests brief
  actuator_parameter_supervisor #(.MS_CYCLES(4)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pos_i(pos_i), .moving_i(moving_i), .servo_on_i(servo_on_i),
    .push_active_i(push_active_i), .at_push_level_i(at_push_level_i), .teach_mode_i(teach_mode_i),
    .jog_i(jog_i), .capture_i(capture_i), .capture_idx_i(capture_idx_i), .zone_a_output_o(zone_a_output_o),
    .zone_b_output_o(zone_b_output_o), .moving_output_o(moving_output_o), .soft_limit_pos_o(soft_limit_pos_o),
    .soft_limit_neg_o(soft_limit_neg_o), .push_done_o(push_done_o), .home_dir_o(home_dir_o),
    .home_offset_o(home_offset_o), .jog_speed_o(jog_speed_o), .hold_cur_limit_o(hold_cur_limit_o),
    .home_cur_limit_o(home_cur_limit_o), .phase_detect_o(phase_detect_o), .phase_dir_o(phase_dir_o));
  host_model host_u (.clock_i(clock_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  // 250 MHz clock
  always #2 clock_i = ~clock_i;
  ////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic pchk(input logic [4:0] n, input logic [31:0] e);
    host_u.rd({1'b0, n, 2'b00}, q);
    check(q, e);
  endtask : pchk
  // Servo on, watch for a pulse, then servo off
  task automatic servo_watch;
    cyc(2);
    servo_on_i <= 1'b1;
    hit = 1'b0;
    repeat (8) begin
      @(posedge clock_i);
      hit = hit | phase_detect_o;
    end
    servo_on_i <= 1'b0;
  endtask : servo_watch
  task automatic t_defaults;
    host_u.rd(8'h00, q);
    check({q[30:0], host_u.last_err}, 32'h1);
    pchk(`P_JOG_SPEED, `RST_JOG);
    pchk(`P_PUSH_MS, `RST_PUSH_MS);
    pchk(`P_DEF_BAND, `RST_BAND);
    pchk(`P_DEF_AMAX, `RST_ZERO);
    $display("defaults done");
  endtask : t_defaults
  task automatic t_restart;
    host_u.set_param(`P_JOG_SPEED, 32'h20);
    pchk(`P_JOG_SPEED, `RST_JOG);
    teach_mode_i <= 1'b1;
    jog_i <= 1'b1;
    cyc(2);
    check({16'h0, jog_speed_o}, `RST_JOG);
    host_u.restart();
    check({16'h0, jog_speed_o}, 32'h20);
    jog_i <= 1'b0;
    cyc(2);
    check({16'h0, jog_speed_o}, 32'h0);
    $display("restart done");
  endtask : t_restart
  task automatic t_zones;
    logic [31:0] pv [10] = '{32'h10, 32'h11, 32'h63, 32'h64, 32'hC8, 32'hC9, 32'h10E, 32'h12C, 32'h114, 32'h113};
    logic [4:0] ev [10] = '{5'h04, 5'h00, 5'h00, 5'h02, 5'h02, 5'h00, 5'h01, 5'h08, 5'h00, 5'h01};
    host_u.set_param(`P_ZONE_A_POS, 32'hC8);
    host_u.set_param(`P_ZONE_A_NEG, 32'h64);
    host_u.set_param(`P_ZONE_B_POS, 32'h113);
    host_u.set_param(`P_ZONE_B_NEG, 32'h10E);
    host_u.set_param(`P_SOFT_POS, 32'h12C);
    host_u.set_param(`P_SOFT_NEG, 32'h10);
    host_u.set_param(`P_PIO_PAT, `PIO_TWO_ZONE);
    host_u.restart();
    moving_i <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      pos_i <= pv[i];
      cyc(2);
      check({27'h0, flags}, {27'h0, ev[i]});
    end
    host_u.set_param(`P_PIO_PAT, 32'h0);
    host_u.restart();
    check({27'h0, flags}, 32'h10);
    moving_i <= 1'b0;
    $display("zones done");
  endtask : t_zones
  task automatic t_table;
    host_u.set_param(`P_DEF_SPEED, 32'h55);
    host_u.set_param(`P_DEF_ACCEL, 32'h11);
    host_u.set_param(`P_DEF_BAND, 32'h22);
    host_u.set_param(`P_DEF_AMAX, 32'h1);
    host_u.set_param(`P_HOME_OFS, 32'h40);
    host_u.set_param(`P_HOME_DIR, 32'h1);
    host_u.set_param(`P_HOLD_CUR, 32'h5A);
    host_u.set_param(`P_HOME_CUR, 32'h5A);
    host_u.restart();
    check(home_offset_o, 32'h40);
    check({home_cur_limit_o, hold_cur_limit_o, 15'h0, home_dir_o}, 32'h4B460001);
    host_u.wr(`REG_TBL_IDX, 32'h2);
    host_u.wr(`REG_TBL_TGT, 32'h123);
    host_u.rd(`REG_TBL_ATTR, q);
    check(q, 32'h00110055);
    host_u.rd(`REG_TBL_BAND, q);
    check(q, 32'hC0000022);
    host_u.set_param(`P_DEF_SPEED, 32'h66);
    host_u.restart();
    host_u.wr(`REG_TBL_TGT, 32'h124);
    host_u.rd(`REG_TBL_ATTR, q);
    check(q, 32'h00110055);
    pos_i <= 32'h77;
    capture_idx_i <= 4'h3;
    capture_i <= 1'b1;
    cyc(1);
    capture_i <= 1'b0;
    host_u.wr(`REG_TBL_IDX, 32'h3);
    host_u.rd(`REG_TBL_TGT, q);
    check(q, 32'h77);
    host_u.rd(`REG_TBL_ATTR, q);
    check(q, 32'h00110066);
    teach_mode_i <= 1'b0;
    host_u.set_param(`P_HOME_DIR, 32'h0);
    host_u.restart();
    host_u.rd(`REG_TBL_BAND, q);
    check({31'h0, q[31]}, 32'h0);
    $display("table done");
  endtask : t_table
  // Tick is 4 cycles: any 4k-cycle span holds exactly k ticks
  task automatic t_push;
    host_u.set_param(`P_PUSH_MS, 32'h5);
    host_u.restart();
    push_active_i <= 1'b1;
    at_push_level_i <= 1'b1;
    cyc(12);
    at_push_level_i <= 1'b0;
    cyc(4);
    at_push_level_i <= 1'b1;
    cyc(16);
    check({31'h0, push_done_o}, 32'h1);
    at_push_level_i <= 1'b0;
    cyc(40);
    check({31'h0, push_done_o}, 32'h0);
    at_push_level_i <= 1'b1;
    cyc(16);
    check({31'h0, push_done_o}, 32'h0);
    cyc(8);
    check({31'h0, push_done_o}, 32'h1);
    push_active_i <= 1'b0;
    cyc(3);
    check({31'h0, push_done_o}, 32'h0);
    $display("push done");
  endtask : t_push
  task automatic t_phase;
    host_u.set_param(`P_PHASE_DIR, 32'h0);
    host_u.set_param(`P_HOME_DIR, 32'h1);
    host_u.restart();
    servo_watch();
    check({30'h0, hit, phase_dir_o}, 32'h2);
    servo_watch();
    check({31'h0, hit}, 32'h0);
    rst_n_i <= 1'b0;
    cyc(3);
    rst_n_i <= 1'b1;
    host_u.set_param(`P_PHASE_DIR, 32'h1);
    host_u.set_param(`P_HOME_DIR, 32'h1);
    host_u.restart();
    servo_watch();
    check({30'h0, hit, phase_dir_o}, 32'h3);
    $display("phase done");
  endtask : t_phase
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  ////////////////////
  // Main sequence
  initial begin
    cyc(3);
    rst_n_i <= 1'b1;
    t_defaults();
    t_restart();
    t_zones();
    t_table();
    t_push();
    t_phase();
    print_verdict();
  end
  // About 400 cycles needed; wide margin
  initial begin
    #80000;
    error_cnt++;
    print_verdict();
  end
endmodule : actuator_parameter_supervisor_bench
`default_nettype wire

// ==== bench/host_model.sv ====
`include "actuator_defines.svh"
`default_nettype none
module host_model (
  // Clock
  input wire logic clock_i,
  // APB master side
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_err;
  ////////////////////
  // Idle bus from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h0;
    pwdata_o = 32'h0;
  end
  // One transfer; held until pready is sampled
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clock_i);
    penable_o <= 1'b1;
    do @(posedge clock_i); while (pready_i !== 1'b1);
    q = prdata_i;
    last_err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // Host clamps current limits to their ceilings
  task automatic set_param(input logic [4:0] n, input logic [31:0] v);
    logic [31:0] w;
    w = v;
    if (n == `P_HOLD_CUR && w > 32'h46) w = 32'h46;
    if (n == `P_HOME_CUR && w > 32'h4B) w = 32'h4B;
    wr({1'b0, n, 2'b00}, w);
  endtask : set_param
  // Software restart, then settling while it applies
  task automatic restart;
    wr(`REG_CTRL, 32'h1);
    repeat (4) @(posedge clock_i);
  endtask : restart
endmodule : host_model
`default_nettype wire

// ==== include/actuator_defines.svh ====
// What this block does
// [R1] New parameters act only after restart
// [R2] Soft limits from parameters 3 and 4
// [R3] Zone output high only inside boundaries
// [R4] Zone A boundaries from parameters 1, 2
// [R5] Zone B only in two-zone pattern
// [R6] Pattern 3 drops moving, adds zone B
// [R7] Home direction bit; reversal clears table
// [R8] Home offset from parameter 22
// [R9] Teach jog speed from parameter 26
// [R10] New entries get default speed, acceleration
// [R11] New entries get default in-position band
// [R12] New entries copy acceleration-only-maximum flag
// [R13] Push done after parameter 6 milliseconds
// [R14] Push count falls per ms, resumes upward
// [R15] Push count saturates at zero
// [R16] Host keeps standstill current at most 70%
// [R17] Host keeps homing current at most 75%
// [R18] Phase detection once, first servo-on
// [R19] Detection direction relative to home direction; code outputs the parameter 28 bit unchanged, whatever the home direction
`ifndef ACTUATOR_DEFINES_SVH
`define ACTUATOR_DEFINES_SVH
////////////////////////////////////////////////////////////////////////
// Parameter numbers; byte address is four times the number
`define P_ZONE_A_POS 5'd1
`define P_ZONE_A_NEG 5'd2
`define P_SOFT_POS 5'd3
`define P_SOFT_NEG 5'd4
`define P_HOME_DIR 5'd5
`define P_PUSH_MS 5'd6
`define P_DEF_SPEED 5'd8
`define P_DEF_ACCEL 5'd9
`define P_DEF_BAND 5'd10
`define P_DEF_AMAX 5'd11
`define P_HOLD_CUR 5'd12
`define P_HOME_CUR 5'd13
`define P_HOME_OFS 5'd22
`define P_ZONE_B_POS 5'd23
`define P_ZONE_B_NEG 5'd24
`define P_PIO_PAT 5'd25
`define P_JOG_SPEED 5'd26
`define P_PHASE_DIR 5'd28
`define P_LAST 5'd28
////////////////////////////////////////////////////////////////////////
// Extra register byte addresses
`define REG_CTRL 8'h80
`define REG_STATUS 8'h84
`define REG_TBL_IDX 8'h88
`define REG_TBL_TGT 8'h8C
`define REG_TBL_ATTR 8'h90
`define REG_TBL_BAND 8'h94
`define CTRL_RESTART_BIT 0
////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_STROKE_POS 32'h00001F40
`define RST_STROKE_NEG 32'h00000000
`define RST_PUSH_MS 32'h000000FF
`define RST_SPEED 32'h000000C8
`define RST_ACCEL 32'h0000001E
`define RST_BAND 32'h0000000A
`define RST_CUR 32'h00000032
`define RST_JOG 32'h00000064
`define RST_ZERO 32'h00000000
`define PIO_TWO_ZONE 32'h00000003
////////////////////////////////////////////////////////////////////////
// Timing
`define MS_NS 1000000
`define CLK_NS 4
`define MS_CYCLES (`MS_NS / `CLK_NS)
`endif

// ==== include/actuator_pkg.sv ====
`default_nettype none
package actuator_pkg;
  typedef logic [31:0] word_t;
  typedef logic signed [31:0] pos_t;
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_APPLY = 1'b1
  } sup_state_t;
endpackage : actuator_pkg
`default_nettype wire

// ==== src/actuator_parameter_supervisor.sv ====
`include "actuator_defines.svh"
`default_nettype none
module actuator_parameter_supervisor #(
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int TBL_DEPTH = 16,
  parameter int IDX_W = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive side status
  input wire actuator_pkg::pos_t pos_i,
  input wire logic moving_i,
  input wire logic servo_on_i,
  input wire logic push_active_i,
  input wire logic at_push_level_i,
  // Teaching inputs
  input wire logic teach_mode_i,
  input wire logic jog_i,
  input wire logic capture_i,
  input wire logic [IDX_W-1:0] capture_idx_i,
  // Position supervision outputs
  output logic zone_a_output_o,
  output logic zone_b_output_o,
  output logic moving_output_o,
  output logic soft_limit_pos_o,
  output logic soft_limit_neg_o,
  output logic push_done_o,
  // Drive settings
  output logic home_dir_o,
  output actuator_pkg::pos_t home_offset_o,
  output logic [15:0] jog_speed_o,
  output logic [7:0] hold_cur_limit_o,
  output logic [7:0] home_cur_limit_o,
  output logic phase_detect_o,
  output logic phase_dir_o
);
  import actuator_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  word_t shadow_r [1:28];
  word_t active_r [1:28];
  sup_state_t state_r;
  logic restart_req;
  logic acc_wr;
  logic acc_any;
  logic [4:0] pidx;
  logic pmap;
  logic [IDX_W-1:0] tbl_idx_r;
  logic tbl_vld_r [TBL_DEPTH];
  pos_t tbl_tgt_r [TBL_DEPTH];
  logic [15:0] tbl_spd_r [TBL_DEPTH];
  logic [15:0] tbl_acc_r [TBL_DEPTH];
  logic [15:0] tbl_band_r [TBL_DEPTH];
  logic tbl_amax_r [TBL_DEPTH];
  logic tbl_wr;
  logic [IDX_W-1:0] tbl_wr_idx;
  pos_t tbl_wr_val;
  logic dir_flip;
  logic [31:0] ms_cnt_r;
  logic ms_tick_r;
  logic phase_done_r;
  logic servo_on_d_r;
  logic [31:0] rdata_nxt;
  logic rerr_nxt;

  // Reset value of each parameter
  function automatic word_t param_default(input logic [4:0] n);
    case (n)
      `P_ZONE_A_POS, `P_SOFT_POS, `P_ZONE_B_POS: param_default = `RST_STROKE_POS;
      `P_PUSH_MS: param_default = `RST_PUSH_MS;
      `P_DEF_SPEED: param_default = `RST_SPEED;
      `P_DEF_ACCEL: param_default = `RST_ACCEL;
      `P_DEF_BAND: param_default = `RST_BAND;
      `P_HOLD_CUR, `P_HOME_CUR: param_default = `RST_CUR;
      `P_JOG_SPEED: param_default = `RST_JOG;
      default: param_default = `RST_ZERO;
    endcase
  endfunction : param_default

  ////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state so read data comes from a flop
  assign acc_any = psel && penable && pready;
  assign acc_wr = acc_any && pwrite && !pslverr;
  assign pidx = paddr[6:2];
  assign pmap = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00) && (pidx != 5'd0) && (pidx <= `P_LAST);
  assign restart_req = acc_wr && (paddr == `REG_CTRL) && pwdata[`CTRL_RESTART_BIT];

  // Ready pulses one cycle into the access phase
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // Read mux and unmapped-address check
  always_comb begin
    rdata_nxt = 32'h00000000;
    rerr_nxt = 1'b0;
    if (pmap) begin
      rdata_nxt = pwrite ? 32'h00000000 : active_r[pidx];
    end else begin
      case (paddr)
        `REG_CTRL: rdata_nxt = {31'h00000000, state_r == ST_APPLY};
        `REG_STATUS: rdata_nxt = {25'h0000000, phase_done_r, push_done_o, zone_b_output_o,
                                  zone_a_output_o, soft_limit_neg_o, soft_limit_pos_o, state_r == ST_APPLY};
        `REG_TBL_IDX: rdata_nxt = 32'(tbl_idx_r);
        `REG_TBL_TGT: rdata_nxt = tbl_tgt_r[tbl_idx_r];
        `REG_TBL_ATTR: rdata_nxt = {tbl_acc_r[tbl_idx_r], tbl_spd_r[tbl_idx_r]};
        `REG_TBL_BAND: rdata_nxt = {tbl_vld_r[tbl_idx_r], tbl_amax_r[tbl_idx_r], 14'h0000, tbl_band_r[tbl_idx_r]};
        default: rerr_nxt = 1'b1;
      endcase
    end
  end

  // Registered answer, valid together with pready
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata <= pwrite ? 32'h00000000 : rdata_nxt;
      pslverr <= rerr_nxt;
    end else begin
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parameter storage: writes land in the shadow copy only
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      for (int n = 1; n <= 28; n++) begin
        shadow_r[n] <= param_default(5'(n));
      end
    end else if (acc_wr && pmap) begin
      shadow_r[pidx] <= pwdata;
    end
  end

  // Restart sequencer; power-up reset loads both copies alike
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_RUN: if (restart_req) state_r <= ST_APPLY; // [R1]
        ST_APPLY: state_r <= ST_RUN;
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Live values change only on restart
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      for (int n = 1; n <= 28; n++) begin
        active_r[n] <= param_default(5'(n));
      end
    end else if (state_r == ST_APPLY) begin
      for (int n = 1; n <= 28; n++) begin
        active_r[n] <= shadow_r[n]; // [R1]
      end
    end
  end

  // Direction reversal detected at the moment of applying
  assign dir_flip = (state_r == ST_APPLY) && (shadow_r[`P_HOME_DIR][0] != active_r[`P_HOME_DIR][0]); // [R7]

  ////////////////////////////////////////////////////////////////////////
  // Position table; host writes and teach capture share one port
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tbl_idx_r <= '0;
    end else if (acc_wr && paddr == `REG_TBL_IDX) begin
      tbl_idx_r <= pwdata[IDX_W-1:0];
    end
  end

  // Capture wins over a host write in the same cycle
  assign tbl_wr = (capture_i && teach_mode_i) || (acc_wr && paddr == `REG_TBL_TGT);
  assign tbl_wr_idx = (capture_i && teach_mode_i) ? capture_idx_i : tbl_idx_r;
  assign tbl_wr_val = (capture_i && teach_mode_i) ? pos_i : pos_t'(pwdata);

  genvar e;
  generate
    for (e = 0; e < TBL_DEPTH; e++) begin : g_entry
      always_ff @(posedge clock_i) begin
        if (!rst_n_i || dir_flip) begin // [R7]
          tbl_vld_r[e] <= 1'b0;
          tbl_tgt_r[e] <= '0;
          tbl_spd_r[e] <= '0;
          tbl_acc_r[e] <= '0;
          tbl_band_r[e] <= '0;
          tbl_amax_r[e] <= 1'b0;
        end else if (tbl_wr && tbl_wr_idx == IDX_W'(e)) begin
          tbl_vld_r[e] <= 1'b1;
          tbl_tgt_r[e] <= tbl_wr_val;
          if (!tbl_vld_r[e]) begin
            tbl_spd_r[e] <= active_r[`P_DEF_SPEED][15:0]; // [R10]
            tbl_acc_r[e] <= active_r[`P_DEF_ACCEL][15:0]; // [R10]
            tbl_band_r[e] <= active_r[`P_DEF_BAND][15:0]; // [R11]
            tbl_amax_r[e] <= active_r[`P_DEF_AMAX][0]; // [R12]
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Millisecond enable; long count kept as a parameter for simulation
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ms_cnt_r <= 32'h00000000;
      ms_tick_r <= 1'b0;
    end else if (ms_cnt_r == 32'(MS_CYCLES - 1)) begin
      ms_cnt_r <= 32'h00000000;
      ms_tick_r <= 1'b1;
    end else begin
      ms_cnt_r <= ms_cnt_r + 32'h00000001;
      ms_tick_r <= 1'b0;
    end
  end

  // Push-and-hold judgment, cleared while parameters reload
  push_hold_counter #(
    .W(8)
  ) u_push (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_i(ms_tick_r),
    .active_i(push_active_i && state_r == ST_RUN),
    .at_level_i(at_push_level_i),
    .period_i(active_r[`P_PUSH_MS][7:0]), // [R13]
    .done_o(push_done_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Zone comparators
  zone_comparator u_zone_a (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .enable_i(1'b1),
    .pos_i(pos_i),
    .upper_i(pos_t'(active_r[`P_ZONE_A_POS])), // [R4]
    .lower_i(pos_t'(active_r[`P_ZONE_A_NEG])), // [R4]
    .inside_o(zone_a_output_o)
  );

  zone_comparator u_zone_b (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .enable_i(active_r[`P_PIO_PAT] == `PIO_TWO_ZONE), // [R5]
    .pos_i(pos_i),
    .upper_i(pos_t'(active_r[`P_ZONE_B_POS])), // [R5]
    .lower_i(pos_t'(active_r[`P_ZONE_B_NEG])), // [R5]
    .inside_o(zone_b_output_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Soft limits and moving status; moving gives way to zone B
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      soft_limit_pos_o <= 1'b0;
      soft_limit_neg_o <= 1'b0;
      moving_output_o <= 1'b0;
    end else begin
      soft_limit_pos_o <= pos_i >= pos_t'(active_r[`P_SOFT_POS]); // [R2]
      soft_limit_neg_o <= pos_i <= pos_t'(active_r[`P_SOFT_NEG]); // [R2]
      moving_output_o <= moving_i && (active_r[`P_PIO_PAT] != `PIO_TWO_ZONE); // [R6]
    end
  end

  // Settings handed to the drive
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      home_dir_o <= 1'b0;
      home_offset_o <= '0;
      jog_speed_o <= 16'h0000;
      hold_cur_limit_o <= 8'h00;
      home_cur_limit_o <= 8'h00;
    end else begin
      home_dir_o <= active_r[`P_HOME_DIR][0]; // [R7]
      home_offset_o <= pos_t'(active_r[`P_HOME_OFS]); // [R8]
      jog_speed_o <= (teach_mode_i && jog_i) ? active_r[`P_JOG_SPEED][15:0] : 16'h0000; // [R9]
      // Passed as set; the host keeps them inside their safe ceilings
      hold_cur_limit_o <= active_r[`P_HOLD_CUR][7:0]; // [R16]
      home_cur_limit_o <= active_r[`P_HOME_CUR][7:0]; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase detection; a soft restart does not rearm it, only power-up
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      servo_on_d_r <= 1'b0;
      phase_done_r <= 1'b0;
      phase_detect_o <= 1'b0;
      phase_dir_o <= 1'b0;
    end else begin
      servo_on_d_r <= servo_on_i;
      phase_detect_o <= 1'b0;
      if (servo_on_i && !servo_on_d_r && !phase_done_r) begin // [R18]
        phase_done_r <= 1'b1;
        phase_detect_o <= 1'b1;
        // Same value follows homing, differing value goes against it
        phase_dir_o <= (active_r[`P_PHASE_DIR][0] == active_r[`P_HOME_DIR][0]) ?
                       active_r[`P_HOME_DIR][0] : !active_r[`P_HOME_DIR][0]; // [R19]
      end
    end
  end
endmodule : actuator_parameter_supervisor
`default_nettype wire

// ==== src/push_hold_counter.sv ====
`default_nettype none
module push_hold_counter #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Controls
  input wire logic tick_i,
  input wire logic active_i,
  input wire logic at_level_i,
  input wire logic [W-1:0] period_i,
  // Result
  output logic done_o
);
  logic [W-1:0] count_r;
  // Up at push level, down below it; resumes from where it fell
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !active_i) begin
      count_r <= '0;
    end else if (tick_i) begin
      if (at_level_i) begin
        if (count_r < period_i) count_r <= count_r + 1'b1; // [R13]
      end else if (count_r != '0) begin // [R15]
        count_r <= count_r - 1'b1; // [R14]
      end
    end
  end
  // Done while the count has reached the period
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= active_i && (count_r >= period_i); // [R13]
    end
  end
endmodule : push_hold_counter
`default_nettype wire

// ==== src/zone_comparator.sv ====
`default_nettype none
module zone_comparator (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Compare inputs
  input wire logic enable_i,
  input wire actuator_pkg::pos_t pos_i,
  input wire actuator_pkg::pos_t upper_i,
  input wire actuator_pkg::pos_t lower_i,
  // Result
  output logic inside_o
);
  import actuator_pkg::*;
  // Inclusive window, registered so the top output comes from a flop
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      inside_o <= 1'b0;
    end else begin
      inside_o <= enable_i && (pos_i >= lower_i) && (pos_i <= upper_i); // [R3]
    end
  end
endmodule : zone_comparator
`default_nettype wire
